// ===== design/dit_pkg.sv
// Package of constants and types for the drive input terminal command logic
package dit_pkg;
  // Clock and timing
  localparam int  CLK_MHZ          = 250;
  localparam int  RUN_MIN_US       = 2000;
  localparam int  RUN_MIN_CYC      = RUN_MIN_US * CLK_MHZ;
  localparam int  JOG_CLASH_MS     = 500;
  localparam int  JOG_CLASH_CYC    = JOG_CLASH_MS * 1000 * CLK_MHZ;
  // Terminal count and function code width
  localparam int  NUM_TERM         = 7;
  localparam int  CODE_W           = 8;
  localparam int  FREQ_W           = 16;
  // Function codes
  localparam logic [7:0] FN_THREE_WIRE = 8'h02;
  localparam logic [7:0] FN_LOC_REM    = 8'h03;
  localparam logic [7:0] FN_SRC_SEL    = 8'h04;
  localparam logic [7:0] FN_STEP1      = 8'h05;
  localparam logic [7:0] FN_STEP2      = 8'h06;
  localparam logic [7:0] FN_STEP3      = 8'h07;
  localparam logic [7:0] FN_STEP4      = 8'h08;
  localparam logic [7:0] FN_JOG        = 8'h09;
  localparam logic [7:0] FN_UP         = 8'h0A;
  localparam logic [7:0] FN_DOWN       = 8'h0B;
  localparam logic [7:0] FN_FORWARD_JOG       = 8'h0E;
  localparam logic [7:0] FN_REVERSE_JOG       = 8'h0F;
  localparam logic [7:0] FN_ACC1       = 8'h10;
  localparam logic [7:0] FN_ACC2       = 8'h11;
  localparam logic [7:0] FN_RAMP_HOLD  = 8'h12;
  localparam logic [7:0] FN_INV_OFS    = 8'h64;
  // Setting values
  localparam logic [1:0] FSRC_UPDOWN   = 2'h2;
  localparam logic [1:0] ANA_LOWER_LIM = 2'h2;
  // Ramp-time selection codes
  localparam logic [2:0] RAMP_JOG      = 3'h4;
  // Run state
  typedef enum logic [1:0] {
    RUN_IDLE  = 2'b00,
    RUN_GO    = 2'b01,
    RUN_BLOCK = 2'b10
  } dit_run_type;
endpackage : dit_pkg

// ===== design/dit_sync.sv
// Three-stage input synchroniser that accepts a change when stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module dit_sync #(
  parameter int W = 7
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Raw and clean levels
  input  wire logic [W-1:0] raw,
  output logic      [W-1:0] clean
);
  logic [W-1:0] s1_q;  // First stage, read only by s2
  logic [W-1:0] s2_q;  // Second stage
  logic [W-1:0] s3_q;  // Third stage

  // Shift chain
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Accept per bit once two stages agree
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          clean[i] <= 1'b0;
        end else if (s2_q[i] == s3_q[i]) begin
          clean[i] <= s3_q[i];
        end
      end
    end
  endgenerate
endmodule : dit_sync
`default_nettype wire

// ===== design/dit_timer.sv
// Counter that flags when a condition has held for a set number of cycles
`timescale 1ns/100ps
`default_nettype none
module dit_timer #(
  parameter int LIMIT = 4
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Condition and result
  input  wire logic cond,
  output logic      done
);
  localparam int CW = $clog2(LIMIT + 1);
  localparam logic [CW-1:0] LIM = CW'(LIMIT);
  logic [CW-1:0] cnt_q;  // Cycles held so far

  // Count while held, clear on release
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (!cond) begin
      cnt_q <= '0;
    end else if (cnt_q != LIM) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  assign done = cond && (cnt_q == LIM);
endmodule : dit_timer
`default_nettype wire

// ===== design/dit_core.sv
// Command logic for multi-function digital input terminals
`timescale 1ns/100ps
`default_nettype none
module dit_core
  import dit_pkg::*;
#(
  parameter int RUN_MIN_CYCLES   = RUN_MIN_CYC,
  parameter int JOG_CLASH_CYCLES = JOG_CLASH_CYC,
  parameter int FW               = FREQ_W
) (
  // Clock and reset
  input  wire logic                       CORE_CLK,
  input  wire logic                       RSTN,
  // Terminal pins and their function codes
  input  wire logic [NUM_TERM-1:0]        TERMINAL_IN,
  input  wire logic [NUM_TERM*CODE_W-1:0] TERMINAL_FUNCTION_SELECT,
  // Keypad and settings
  input  wire logic                       LOCAL_REMOTE_KEY,
  input  wire logic                       KEYPAD_RUN,
  input  wire logic                       POWERUP_RUN_ACCEPT,
  input  wire logic                       REVERSE_INHIBIT,
  input  wire logic                       FREQ_CMD_RETAIN,
  input  wire logic [1:0]                 FREQ_SOURCE_SEL_1,
  input  wire logic [1:0]                 RUN_SOURCE_SEL_1,
  input  wire logic [1:0]                 FREQ_SOURCE_SEL_2,
  input  wire logic [1:0]                 RUN_SOURCE_SEL_2,
  input  wire logic [1:0]                 ANALOG_FUNC_SEL,
  input  wire logic                       EXT_RUN_REQ,
  input  wire logic                       EXT_REVERSE,
  // Frequency values
  input  wire logic [16*FW-1:0]           PRESET_FREQ,
  input  wire logic [FW-1:0]              JOG_FREQ_VALUE,
  input  wire logic [FW-1:0]              FREQ_UPPER_LIMIT,
  input  wire logic [FW-1:0]              FREQ_LOWER_LIMIT,
  input  wire logic [FW-1:0]              ANALOG_VALUE,
  input  wire logic [FW-1:0]              UPDOWN_STEP,
  input  wire logic                       RAMP_TICK,
  // Command results
  output logic                            RUN_CMD,
  output logic                            REVERSE_CMD,
  output logic                            LOCAL_MODE,
  output logic                            LOCAL_LED,
  output logic                            LED_FLASH,
  output logic                            POWERUP_FAULT,
  output logic                            SOURCE2_ACTIVE,
  output logic [1:0]                      FREQ_SOURCE_ACTIVE,
  output logic [1:0]                      RUN_SOURCE_ACTIVE,
  output logic [FW-1:0]                   FREQ_REF,
  output logic [FW-1:0]                   UPDOWN_FREQ,
  output logic                            JOG_RAMP_SEL,
  output logic [2:0]                      RAMP_SEL,
  output logic                            RAMP_HOLD,
  output logic                            INPUT_SELECT_ERROR,
  output logic                            JOG_CLASH_ALARM
);
  logic [NUM_TERM-1:0] pin_s;        // Synchronised pin levels
  logic [NUM_TERM-1:0] act;          // Pin level after sense inversion
  logic                three_wire;   // Any of terminals three to seven uses code 2
  logic                f_dir, f_lr, f_src, f_jog, f_up, f_down, f_fj, f_rj;
  logic                f_a1, f_a2, f_hold, a_lr, a_src;
  logic                as_lr, as_src, as_up, as_down, as_hold;
  logic [3:0]          step_sel;     // Preset select bits
  logic                run_raw;      // Run request before power-up check
  logic                run_long;     // Run input held long enough
  logic                clash;        // Both jogs held long enough
  logic                fj_eff, rj_eff;
  logic                motor_on;
  logic                local_q, src2_q, first_q;
  logic                tw_latch_q;   // Three-wire run latch
  logic [FW-1:0]       ud_q;         // Up/down frequency
  logic [FW-1:0]       lower_lim;
  logic [FW-1:0]       ud_sum;
  logic                clash_q;
  dit_run_type         run_st_q;

  // Synchronise all terminal pins
  dit_sync #(.W(NUM_TERM)) u_sync (
    .clk   (CORE_CLK),
    .rst_n (RSTN),
    .raw   (TERMINAL_IN),
    .clean (pin_s)
  );

  // Decode codes per terminal, with inverted sense for codes of a hundred and up
  logic [NUM_TERM-1:0] m_dir, m_lr, m_src, m_jog, m_up, m_dn, m_fj, m_rj;
  logic [NUM_TERM-1:0] m_a1, m_a2, m_hold, m_s1, m_s2, m_s3, m_s4;
  genvar t;
  generate
    for (t = 0; t < NUM_TERM; t++) begin : g_term
      logic [CODE_W-1:0] raw_c, base_c;
      logic              inv;
      assign raw_c  = TERMINAL_FUNCTION_SELECT[t*CODE_W +: CODE_W];
      assign inv    = raw_c >= FN_INV_OFS;
      assign base_c = inv ? raw_c - FN_INV_OFS : raw_c;
      assign act[t] = pin_s[t] ^ inv;
      assign m_dir[t]  = (t >= 2) && (base_c == FN_THREE_WIRE);
      assign m_lr[t]   = base_c == FN_LOC_REM;
      assign m_src[t]  = base_c == FN_SRC_SEL;
      assign m_s1[t]   = base_c == FN_STEP1;
      assign m_s2[t]   = base_c == FN_STEP2;
      assign m_s3[t]   = base_c == FN_STEP3;
      assign m_s4[t]   = base_c == FN_STEP4;
      assign m_jog[t]  = base_c == FN_JOG;
      assign m_up[t]   = base_c == FN_UP;
      assign m_dn[t]   = base_c == FN_DOWN;
      assign m_fj[t]   = base_c == FN_FORWARD_JOG;
      assign m_rj[t]   = base_c == FN_REVERSE_JOG;
      assign m_a1[t]   = base_c == FN_ACC1;
      assign m_a2[t]   = base_c == FN_ACC2;
      assign m_hold[t] = base_c == FN_RAMP_HOLD;
    end
  endgenerate

  // Assigned flags and active levels of each function
  assign three_wire = |m_dir;
  assign as_lr   = |m_lr;
  assign as_src  = |m_src;
  assign as_up   = |m_up;
  assign as_down = |m_dn;
  assign as_hold = |m_hold;
  assign f_dir   = |(m_dir & act);
  assign a_lr    = |(m_lr & act);
  assign a_src   = |(m_src & act);
  assign f_jog   = |(m_jog & act);
  assign f_up    = |(m_up & act);
  assign f_down  = |(m_dn & act);
  assign f_fj    = |(m_fj & act);
  assign f_rj    = |(m_rj & act);
  assign f_a1    = |(m_a1 & act);
  assign f_a2    = |(m_a2 & act);
  assign f_hold  = |(m_hold & act);
  assign f_lr    = a_lr;
  assign f_src   = a_src;
  assign step_sel = {|(m_s4 & act), |(m_s3 & act), |(m_s2 & act), |(m_s1 & act)};

  // Run input held timer for three-wire start
  dit_timer #(.LIMIT(RUN_MIN_CYCLES)) u_run_tmr (
    .clk   (CORE_CLK),
    .rst_n (RSTN),
    .cond  (three_wire && act[0]),
    .done  (run_long)
  );

  // Both-jog clash timer
  dit_timer #(.LIMIT(JOG_CLASH_CYCLES)) u_jog_tmr (
    .clk   (CORE_CLK),
    .rst_n (RSTN),
    .cond  (f_fj && f_rj),
    .done  (clash)
  );

  // Three-wire run latch: set by long run, cleared at once by open stop
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      tw_latch_q <= 1'b0;
    end else if (!three_wire || !act[1]) begin
      tw_latch_q <= 1'b0;
    end else if (run_long) begin
      tw_latch_q <= 1'b1;
    end
  end

  // Run request from the active source
  always_comb begin
    if (local_q) begin
      run_raw = KEYPAD_RUN;
    end else if (three_wire) begin
      run_raw = tw_latch_q && act[1];
    end else begin
      run_raw = EXT_RUN_REQ;
    end
  end

  // Jog qualification
  assign rj_eff = f_rj && !REVERSE_INHIBIT;
  assign fj_eff = f_fj;

  // Power-up run check: refuse a run present at the first sample
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      run_st_q <= RUN_IDLE;
      first_q  <= 1'b1;
    end else begin
      first_q <= 1'b0;
      case (run_st_q)
        RUN_IDLE: begin
          if (first_q && run_raw && !POWERUP_RUN_ACCEPT) begin
            run_st_q <= RUN_BLOCK;
          end else if (run_raw) begin
            run_st_q <= RUN_GO;
          end
        end
        RUN_GO: begin
          if (!run_raw) begin
            run_st_q <= RUN_IDLE;
          end
        end
        RUN_BLOCK: begin
          if (!run_raw) begin
            run_st_q <= RUN_IDLE;
          end
        end
        default: run_st_q <= RUN_IDLE;
      endcase
    end
  end

  // Jog clash alarm stays until either jog releases
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      clash_q <= 1'b0;
    end else if (clash) begin
      clash_q <= 1'b1;
    end else if (!f_fj || !f_rj) begin
      clash_q <= 1'b0;
    end
  end

  assign motor_on = RUN_CMD;

  // Local/remote and source pair, updated only while stopped
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      local_q <= 1'b0;
      src2_q  <= 1'b0;
    end else if (!motor_on) begin
      if (as_lr) begin
        local_q <= f_lr;
      end else if (LOCAL_REMOTE_KEY) begin
        local_q <= ~local_q;
      end
      src2_q <= as_src && f_src;
    end
  end

  // Active source selections
  always_comb begin
    if (src2_q) begin
      FREQ_SOURCE_ACTIVE = FREQ_SOURCE_SEL_2;
      RUN_SOURCE_ACTIVE  = RUN_SOURCE_SEL_2;
    end else begin
      FREQ_SOURCE_ACTIVE = FREQ_SOURCE_SEL_1;
      RUN_SOURCE_ACTIVE  = RUN_SOURCE_SEL_1;
    end
  end

  // Up/down limits
  assign lower_lim = (ANALOG_FUNC_SEL == ANA_LOWER_LIM && ANALOG_VALUE < FREQ_LOWER_LIMIT) ?
                     ANALOG_VALUE : FREQ_LOWER_LIMIT;
  assign ud_sum = ud_q + UPDOWN_STEP;

  // Up/down frequency register
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      ud_q <= '0;
    end else if (!RUN_CMD && !FREQ_CMD_RETAIN) begin
      ud_q <= '0;
    end else if (!RUN_CMD && (f_up || f_down)) begin
      ud_q <= '0;
    end else if (RUN_CMD && FREQ_SOURCE_ACTIVE == FSRC_UPDOWN && as_up && as_down
                 && RAMP_TICK) begin
      if (f_up && !f_down) begin
        ud_q <= (ud_sum < ud_q || ud_sum > FREQ_UPPER_LIMIT) ? FREQ_UPPER_LIMIT : ud_sum;
      end else if (f_down && !f_up) begin
        ud_q <= (ud_q < lower_lim + UPDOWN_STEP) ? lower_lim : ud_q - UPDOWN_STEP;
      end else if (ud_q < lower_lim) begin
        ud_q <= lower_lim;
      end
    end
  end

  // Registered command outputs
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      RUN_CMD            <= 1'b0;
      REVERSE_CMD        <= 1'b0;
      FREQ_REF           <= '0;
      JOG_RAMP_SEL       <= 1'b0;
      RAMP_SEL           <= '0;
      RAMP_HOLD          <= 1'b0;
      INPUT_SELECT_ERROR <= 1'b0;
      JOG_CLASH_ALARM    <= 1'b0;
      LOCAL_MODE         <= 1'b0;
      LOCAL_LED          <= 1'b0;
      POWERUP_FAULT      <= 1'b0;
      LED_FLASH          <= 1'b0;
      SOURCE2_ACTIVE     <= 1'b0;
      UPDOWN_FREQ        <= '0;
    end else begin
      INPUT_SELECT_ERROR <= as_up ^ as_down;
      JOG_CLASH_ALARM    <= clash_q;
      LOCAL_MODE         <= local_q;
      LOCAL_LED          <= local_q;
      POWERUP_FAULT      <= run_st_q == RUN_BLOCK;
      LED_FLASH          <= run_st_q == RUN_BLOCK;
      SOURCE2_ACTIVE     <= src2_q;
      UPDOWN_FREQ        <= ud_q;
      RAMP_HOLD          <= as_hold && f_hold;
      if (clash_q || clash) begin
        RUN_CMD      <= 1'b0;
        JOG_RAMP_SEL <= 1'b0;
        FREQ_REF     <= '0;
        RAMP_SEL     <= {1'b0, f_a2, f_a1};
      end else if (fj_eff || rj_eff) begin
        RUN_CMD      <= 1'b1;
        REVERSE_CMD  <= rj_eff && !fj_eff;
        FREQ_REF     <= JOG_FREQ_VALUE;
        JOG_RAMP_SEL <= 1'b1;
        RAMP_SEL     <= RAMP_JOG;
      end else begin
        RUN_CMD      <= run_st_q == RUN_GO && run_raw && !(three_wire && !act[1]);
        REVERSE_CMD  <= three_wire ? f_dir : EXT_REVERSE;
        JOG_RAMP_SEL <= f_jog;
        RAMP_SEL     <= f_jog ? RAMP_JOG : {1'b0, f_a2, f_a1};
        if (f_jog) begin
          FREQ_REF <= JOG_FREQ_VALUE;
        end else if (FREQ_SOURCE_ACTIVE == FSRC_UPDOWN && !local_q) begin
          FREQ_REF <= ud_q;
        end else begin
          FREQ_REF <= PRESET_FREQ[step_sel*FW +: FW];
        end
      end
    end
  end
endmodule : dit_core
`default_nettype wire

// ===== verif/dit_contacts.sv
// Contact bank model that drives the terminal pins
`timescale 1ns/100ps
`default_nettype none
module dit_contacts (
  // Clock for contact updates
  input  wire logic       clk,
  // Requested and actual contact levels
  input  wire logic [6:0] want,
  output logic      [6:0] pins
);
  // Contacts move at the falling edge, away from sampling
  always @(negedge clk) begin
    pins <= want;
  end
endmodule : dit_contacts
`default_nettype wire

// ===== verif/dit_core_asserts.sv
// Concurrent checks on the terminal command logic ports
`timescale 1ns/100ps
`default_nettype none
module dit_core_chk
  import dit_pkg::*;
#(
  parameter int RUN_MIN_CYCLES = 8,
  parameter int FW             = FREQ_W
) (
  // Clock and reset
  input wire logic                       CORE_CLK,
  input wire logic                       RSTN,
  // Terminals
  input wire logic [NUM_TERM-1:0]        TERMINAL_IN,
  input wire logic [NUM_TERM*CODE_W-1:0] TERMINAL_FUNCTION_SELECT,
  // Results
  input wire logic                       RUN_CMD,
  input wire logic                       REVERSE_CMD,
  input wire logic                       LOCAL_MODE,
  input wire logic                       LOCAL_LED,
  input wire logic                       LED_FLASH,
  input wire logic                       POWERUP_FAULT,
  input wire logic                       SOURCE2_ACTIVE,
  input wire logic [FW-1:0]              FREQ_REF,
  input wire logic [2:0]                 RAMP_SEL,
  input wire logic                       INPUT_SELECT_ERROR,
  input wire logic                       JOG_CLASH_ALARM
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);
  logic        tw_mode;   // Three-wire code on a later terminal
  logic        tw_dir;    // Direction level with sense applied
  logic        has_up;    // Up code present
  logic        has_dn;    // Down code present
  int unsigned run_cnt_q; // Raw run pin closed cycles
  // Decode function codes
  always_comb begin
    logic [7:0] c;
    c = 8'h00;
    tw_mode = 1'b0;
    tw_dir = 1'b0;
    has_up = 1'b0;
    has_dn = 1'b0;
    for (int t = 0; t < NUM_TERM; t++) begin
      c = TERMINAL_FUNCTION_SELECT[t*CODE_W +: CODE_W];
      if (t >= 2 && (c == FN_THREE_WIRE || c == FN_THREE_WIRE + FN_INV_OFS)) begin
        tw_mode = 1'b1;
        tw_dir = tw_dir | (TERMINAL_IN[t] ^ (c >= FN_INV_OFS));
      end
      has_up = has_up | (c == FN_UP) | (c == FN_UP + FN_INV_OFS);
      has_dn = has_dn | (c == FN_DOWN) | (c == FN_DOWN + FN_INV_OFS);
    end
  end
  // Count how long the run pin has stayed closed
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN || !TERMINAL_IN[0]) run_cnt_q <= 0;
    else if (run_cnt_q < 1000) run_cnt_q <= run_cnt_q + 1;
  end
  property p_run_min;
    $rose(RUN_CMD) && tw_mode && RAMP_SEL != RAMP_JOG |-> run_cnt_q > RUN_MIN_CYCLES;
  endproperty
  a_run_min: assert property (p_run_min) else $error("run began too early");
  property p_stop;
    (tw_mode && !TERMINAL_IN[1] && RAMP_SEL != RAMP_JOG) [*2] |-> ##[0:6] !RUN_CMD;
  endproperty
  a_stop: assert property (p_stop) else $error("stop input ignored");
  property p_dir;
    (tw_mode && RUN_CMD && RAMP_SEL != RAMP_JOG && $stable(tw_dir)) [*8]
      |-> REVERSE_CMD == tw_dir;
  endproperty
  a_dir: assert property (p_dir) else $error("wrong direction");
  property p_led;
    LOCAL_MODE && $past(LOCAL_MODE) |-> LOCAL_LED;
  endproperty
  a_led: assert property (p_led) else $error("local indicator dark");
  property p_hold;
    RUN_CMD && $past(RUN_CMD) |-> $stable(LOCAL_MODE) && $stable(SOURCE2_ACTIVE);
  endproperty
  a_hold: assert property (p_hold) else $error("source changed in run");
  property p_sel_err;
    $stable(TERMINAL_FUNCTION_SELECT) && has_up != has_dn |-> ##[0:3] INPUT_SELECT_ERROR;
  endproperty
  a_sel_err: assert property (p_sel_err) else $error("no selection error");
  property p_pwr;
    POWERUP_FAULT && $past(POWERUP_FAULT) |-> !RUN_CMD && LED_FLASH;
  endproperty
  a_pwr: assert property (p_pwr) else $error("power-up run not refused");
  property p_clash;
    JOG_CLASH_ALARM && $past(JOG_CLASH_ALARM) |-> !RUN_CMD && FREQ_REF == '0;
  endproperty
  a_clash: assert property (p_clash) else $error("clash did not stop");
  // Main scenarios reached
  c_tw_run: cover property ($rose(RUN_CMD) && tw_mode);
  c_clash: cover property ($rose(JOG_CLASH_ALARM));
  c_local: cover property ($rose(LOCAL_MODE));
endmodule : dit_core_chk
bind dit_core dit_core_chk #(.RUN_MIN_CYCLES(RUN_MIN_CYCLES), .FW(FW)) u_chk (
  .CORE_CLK(CORE_CLK), .RSTN(RSTN), .TERMINAL_IN(TERMINAL_IN),
  .TERMINAL_FUNCTION_SELECT(TERMINAL_FUNCTION_SELECT), .RUN_CMD(RUN_CMD),
  .REVERSE_CMD(REVERSE_CMD), .LOCAL_MODE(LOCAL_MODE), .LOCAL_LED(LOCAL_LED),
  .LED_FLASH(LED_FLASH), .POWERUP_FAULT(POWERUP_FAULT), .SOURCE2_ACTIVE(SOURCE2_ACTIVE),
  .FREQ_REF(FREQ_REF), .RAMP_SEL(RAMP_SEL), .INPUT_SELECT_ERROR(INPUT_SELECT_ERROR),
  .JOG_CLASH_ALARM(JOG_CLASH_ALARM));
`default_nettype wire

// ===== verif/test_drive_input_terminal_functions.sv
// Self-checking bench for the terminal command logic
`timescale 1ns/100ps
`default_nettype none
module test_drive_input_terminal_functions
  import dit_pkg::*;
;
  logic         clk, rstn, lr_key, kp_run, pw_acc, rev_inh, retain, run_req, ext_rev, tick;
  logic [1:0]   fs1, rs1, fs2, rs2, ana_sel, fsa, rsa;
  logic [15:0]  jog_f, up_lim, lo_lim, ana_v, step, fref, udf;
  logic [255:0] presets;
  logic [55:0]  codes;
  logic [6:0]   want, pins;
  logic [2:0]   rsel;
  logic         run, rev, loc, led, flash, pfault, src2, jramp, rhold, serr, clash;
  int           n_errors, total_checks;
  // Contact bank
  dit_contacts u_sw (.clk(clk), .want(want), .pins(pins));
  // Block under test with short counts
  dit_core #(.RUN_MIN_CYCLES(8), .JOG_CLASH_CYCLES(16)) uut (
    .CORE_CLK(clk), .RSTN(rstn), .TERMINAL_IN(pins), .TERMINAL_FUNCTION_SELECT(codes),
    .LOCAL_REMOTE_KEY(lr_key), .KEYPAD_RUN(kp_run), .POWERUP_RUN_ACCEPT(pw_acc),
    .REVERSE_INHIBIT(rev_inh), .FREQ_CMD_RETAIN(retain), .FREQ_SOURCE_SEL_1(fs1),
    .RUN_SOURCE_SEL_1(rs1), .FREQ_SOURCE_SEL_2(fs2), .RUN_SOURCE_SEL_2(rs2),
    .ANALOG_FUNC_SEL(ana_sel), .EXT_RUN_REQ(run_req), .EXT_REVERSE(ext_rev),
    .PRESET_FREQ(presets), .JOG_FREQ_VALUE(jog_f), .FREQ_UPPER_LIMIT(up_lim),
    .FREQ_LOWER_LIMIT(lo_lim), .ANALOG_VALUE(ana_v), .UPDOWN_STEP(step), .RAMP_TICK(tick),
    .RUN_CMD(run), .REVERSE_CMD(rev), .LOCAL_MODE(loc), .LOCAL_LED(led), .LED_FLASH(flash),
    .POWERUP_FAULT(pfault), .SOURCE2_ACTIVE(src2), .FREQ_SOURCE_ACTIVE(fsa),
    .RUN_SOURCE_ACTIVE(rsa), .FREQ_REF(fref), .UPDOWN_FREQ(udf), .JOG_RAMP_SEL(jramp),
    .RAMP_SEL(rsel), .RAMP_HOLD(rhold), .INPUT_SELECT_ERROR(serr),
    .JOG_CLASH_ALARM(clash));
  // Compare one value
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Compare one flag
  task automatic chk1(input logic got, input logic exp);
    chk({15'h0000, got}, {15'h0000, exp});
  endtask : chk1
  // Wait falling edges
  task automatic w(input int n);
    repeat (n) @(negedge clk);
  endtask : w
  // Step pulses for up/down
  task automatic ticks(input int n);
    repeat (n) begin
      tick = 1'b1;
      w(1);
      tick = 1'b0;
      w(1);
    end
  endtask : ticks
  // Reset for two cycles
  task automatic rst();
    rstn = 1'b0;
    w(2);
    rstn = 1'b1;
  endtask : rst
  // Verdict and end of run
  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : test_done
  // Clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Watchdog
  initial begin
    #80000;
    n_errors++;
    test_done();
  end
  // Test sequence
  initial begin
    {lr_key, kp_run, pw_acc, rev_inh, retain, ext_rev, tick, rs1, rs2, fs1, ana_sel} = '0;
    fs2 = 2'h1;
    rs2 = 2'h3;
    jog_f = 16'h0777;
    up_lim = 16'h0030;
    lo_lim = 16'h0010;
    ana_v = 16'h0008;
    step = 16'h0008;
    for (int k = 0; k < 16; k++) presets[16*k +: 16] = 16'h1000 + 16'(k);
    codes = '0;
    want = '0;
    run_req = 1'b1;
    rstn = 1'b0;
    rst();
    w(6);
    chk1(pfault, 1'b1);
    chk1(flash, 1'b1);
    chk1(run, 1'b0);
    run_req = 1'b0;
    w(4);
    run_req = 1'b1;
    w(4);
    chk1(run, 1'b1);
    pw_acc = 1'b1;
    rst();
    w(6);
    chk1(run, 1'b1);
    chk1(pfault, 1'b0);
    // Presets, inverted sense, jog, ramp pairs and hold
    codes[16 +: 32] = {FN_STEP4, FN_STEP3, FN_STEP2, FN_STEP1};
    for (int k = 0; k < 16; k++) begin
      want[5:2] = 4'(k);
      w(8);
      chk(fref, 16'h1000 + 16'(k));
    end
    codes[16 +: 8] = FN_STEP1 + FN_INV_OFS;
    w(8);
    chk(fref, 16'h100E);
    codes[48 +: 8] = FN_JOG;
    want[6] = 1'b1;
    w(8);
    chk(fref, jog_f);
    chk({13'h0000, rsel}, {13'h0000, RAMP_JOG});
    chk1(jramp, 1'b1);
    codes = '0;
    want = '0;
    codes[16 +: 24] = {FN_RAMP_HOLD, FN_ACC2, FN_ACC1};
    for (int k = 0; k < 4; k++) begin
      want[3:2] = 2'(k);
      w(8);
      chk({13'h0000, rsel}, 16'(k));
    end
    want[4] = 1'b1;
    w(8);
    chk1(rhold, 1'b1);
    // Local/remote and source pairs
    run_req = 1'b0;
    want = '0;
    codes = '0;
    codes[16 +: 16] = {FN_SRC_SEL, FN_LOC_REM};
    want[2] = 1'b1;
    w(8);
    chk1(loc, 1'b1);
    chk1(led, 1'b1);
    lr_key = 1'b1;
    w(1);
    lr_key = 1'b0;
    w(6);
    chk1(loc, 1'b1);
    want[2] = 1'b0;
    want[3] = 1'b1;
    w(8);
    chk1(loc, 1'b0);
    chk1(src2, 1'b1);
    chk({14'h0000, fsa}, {14'h0000, fs2});
    chk({14'h0000, rsa}, {14'h0000, rs2});
    run_req = 1'b1;
    w(6);
    want[3] = 1'b0;
    want[2] = 1'b1;
    w(8);
    chk1(src2, 1'b1);
    chk1(loc, 1'b0);
    run_req = 1'b0;
    w(8);
    chk1(loc, 1'b1);
    want[2] = 1'b0;
    codes[24 +: 8] = 8'h00;
    w(8);
    chk1(loc, 1'b0);
    chk1(src2, 1'b0);
    // Keypad key toggles local only with no terminal assigned
    codes = '0;
    lr_key = 1'b1;
    w(1);
    lr_key = 1'b0;
    w(4);
    chk1(loc, 1'b1);
    lr_key = 1'b1;
    w(1);
    lr_key = 1'b0;
    w(4);
    chk1(loc, 1'b0);
    // Three-wire run, stop and direction
    codes = '0;
    codes[16 +: 8] = FN_THREE_WIRE;
    want[1] = 1'b1;
    w(8);
    want[0] = 1'b1;
    w(4);
    want[0] = 1'b0;
    w(10);
    chk1(run, 1'b0);
    want[0] = 1'b1;
    w(16);
    want[0] = 1'b0;
    w(4);
    chk1(run, 1'b1);
    chk1(rev, 1'b0);
    want[2] = 1'b1;
    w(8);
    chk1(rev, 1'b1);
    want[1] = 1'b0;
    w(2);
    want[1] = 1'b1;
    w(8);
    chk1(run, 1'b0);
    // Forward and reverse jog
    codes = '0;
    want = '0;
    codes[16 +: 16] = {FN_REVERSE_JOG, FN_FORWARD_JOG};
    w(8);
    want[2] = 1'b1;
    w(8);
    chk1(run, 1'b1);
    chk(fref, jog_f);
    want[2] = 1'b0;
    want[3] = 1'b1;
    w(8);
    chk1(rev, 1'b1);
    rev_inh = 1'b1;
    w(8);
    chk1(run, 1'b0);
    rev_inh = 1'b0;
    want[2] = 1'b1;
    w(12);
    chk1(clash, 1'b0);
    w(12);
    chk1(clash, 1'b1);
    chk1(run, 1'b0);
    want = '0;
    w(8);
    chk1(clash, 1'b0);
    // Up/down stepping, limits and retention
    codes = '0;
    codes[16 +: 16] = {FN_DOWN, FN_UP};
    fs1 = FSRC_UPDOWN;
    run_req = 1'b1;
    w(8);
    want[2] = 1'b1;
    ticks(10);
    chk(udf, up_lim);
    want[2] = 1'b0;
    want[3] = 1'b1;
    ticks(10);
    chk(udf, lo_lim);
    ana_sel = ANA_LOWER_LIM;
    ticks(4);
    chk(udf, ana_v);
    want[2] = 1'b1;
    ticks(4);
    chk(udf, ana_v);
    want = '0;
    retain = 1'b1;
    w(8);
    run_req = 1'b0;
    w(8);
    chk(udf, ana_v);
    want[2] = 1'b1;
    w(8);
    chk(udf, 16'h0000);
    ana_v = 16'h0000;
    fs1 = 2'h0;
    run_req = 1'b1;
    ticks(6);
    chk(udf, 16'h0000);
    codes[24 +: 8] = 8'h00;
    w(6);
    chk1(serr, 1'b1);
    test_done();
  end
endmodule : test_drive_input_terminal_functions
`default_nettype wire
